// ===== common/sat_pkg.sv
// Package: register map, field positions, timing constants and carrier types
package sat_pkg;
   // Register byte addresses
   localparam logic [7:0] SAT_A_CTRL = 8'h00;
   localparam logic [7:0] SAT_A_STAT = 8'h04;
   localparam logic [7:0] SAT_A_TDM = 8'h08;
   localparam logic [7:0] SAT_A_GPIO = 8'h0C;
   localparam logic [7:0] SAT_A_PLIM = 8'h10;
   // Control register bit positions
   localparam int SAT_C_ISL_DIS = 0;
   localparam int SAT_C_SURR = 1;
   localparam int SAT_C_TWO_LINE = 2;
   localparam int SAT_C_AUX = 3;
   localparam int SAT_C_TDM = 4;
   localparam int SAT_C_EMB = 5;
   localparam int SAT_CTRL_W = 6;
   // Reset values
   localparam logic [5:0] SAT_CTRL_RST = 6'h00;
   localparam logic [5:0] SAT_WLEN_RST = 6'h1F;
   localparam logic [7:0] SAT_PLIM_RST = 8'h00;
   localparam logic [3:0] SAT_GPIO_RST = 4'h0;
   // Bit clock limits against the 200 MHz system clock
   localparam int SAT_CLK_MHZ = 200;
   localparam int SAT_BCLK_MIN_MHZ = 1;
   localparam int SAT_BCLK_MAX_MHZ = 13;
   localparam int SAT_PER_MAX_CYC = SAT_CLK_MHZ / SAT_BCLK_MIN_MHZ;
   localparam int SAT_PER_MIN_CYC = (SAT_CLK_MHZ + SAT_BCLK_MAX_MHZ - 1) / SAT_BCLK_MAX_MHZ;
   localparam int SAT_NLINE = 5;
   // One captured audio word and its channel slot
   typedef struct packed {
      logic [31:0] data;
      logic [2:0] slot;
   } sat_smp_t;
   // One word handed to the serial link framer
   typedef struct packed {
      sat_smp_t smp;
      logic [2:0] line;
      logic island;
   } sat_link_t;
endpackage : sat_pkg

// ===== verilog/sat_audio_in.sv
// Serial audio input capture, clock check and link transport selection
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module sat_audio_in
   import sat_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic audio_bclk,
   input wire logic audio_word_select,
   input wire logic audio_data_line_a,
   input wire logic audio_data_line_b,
   input wire logic audio_data_line_c,
   input wire logic audio_data_line_d,
   input wire logic [1:0] gpio_in,
   output logic [1:0] gpio_out,
   output logic [1:0] gpio_oe_n,
   input wire logic emb_valid,
   input wire sat_smp_t emb_smp,
   input wire logic blank,
   input wire logic partner_new,
   input wire logic partner_surround,
   input wire logic link_ready,
   output logic link_valid,
   output sat_link_t link_out,
   output logic surround_active,
   output logic bclk_ok
);
   logic [1:0] rst_q;
   logic rs_n;
   logic [SAT_CTRL_W-1:0] ctrl_r;
   logic [5:0] wlen_r;
   logic [7:0] plim_r;
   logic [3:0] gpio_r;
   logic ovr_r;
   logic [7:0] pcnt_r;
   logic [7:0] per_r;
   logic bclk_ok_r;
   logic [1:0] gin_s1, gin_s2;
   logic [5:0] tg_s1, tg_s2, tg_s3;
   logic [5:0] tg_new;
   logic wr_pend_r;
   logic [7:0] wa_r;
   logic [31:0] rd_mux;
   logic isl, emb, surr, allow, load;
   logic [4:0] mask, pend_v, set_v, grant;
   sat_smp_t pend [SAT_NLINE];
   sat_smp_t hold [SAT_NLINE];
   logic out_v_r;
   sat_link_t out_r;
   // Bit clock domain signals
   logic [1:0] brst_q;
   logic brst_n;
   logic [6:0] bcfg_s1, bcfg_s2;
   logic b_tdm;
   logic [5:0] b_wlen;
   logic [4:0] ws_q;
   logic [4:0] wsv, dv;
   logic [5:0] tg_r;
   logic [5:0] wpos_r;
   logic [2:0] sidx_r;
   logic ws_rise;

   // Reset released through two flops; assertion is immediate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rs_n = rst_q[1];

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Read mux; unmapped offsets read zero
   always_comb begin
      if (haddr[7:0] == SAT_A_CTRL) rd_mux = {26'h0, ctrl_r};
      else if (haddr[7:0] == SAT_A_STAT)
         rd_mux = {14'h0, gin_s2, per_r, 5'h0, surround_active, ovr_r, bclk_ok_r};
      else if (haddr[7:0] == SAT_A_TDM) rd_mux = {26'h0, wlen_r};
      else if (haddr[7:0] == SAT_A_GPIO) rd_mux = {28'h0, gpio_r};
      else if (haddr[7:0] == SAT_A_PLIM) rd_mux = {24'h0, plim_r};
      else rd_mux = 32'h0;
   end

   // Address phase: latch write target, fetch read data into a flop
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) begin
         wr_pend_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_r <= hsel & htrans[1] & hready & hwrite;
         if (hsel & htrans[1] & hready) begin
            wa_r <= haddr[7:0];
            if (!hwrite) hrdata <= rd_mux;
         end
      end
   end

   // Data phase writes; hsize ignored since only word transfers are used
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) begin
         ctrl_r <= SAT_CTRL_RST;
         wlen_r <= SAT_WLEN_RST;
         plim_r <= SAT_PLIM_RST;
         gpio_r <= SAT_GPIO_RST;
      end else if (wr_pend_r) begin
         if (wa_r == SAT_A_CTRL) ctrl_r <= hwdata[SAT_CTRL_W-1:0];
         else if (wa_r == SAT_A_TDM) wlen_r <= hwdata[5:0];
         else if (wa_r == SAT_A_GPIO) gpio_r <= hwdata[3:0];
         else if (wa_r == SAT_A_PLIM) plim_r <= hwdata[7:0];
      end
   end

   // Overrun flag: write one to clear, a new overrun wins over the clear
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) ovr_r <= 1'b0;
      else if (|(set_v & pend_v & ~grant)) ovr_r <= 1'b1;
      else if (wr_pend_r && wa_r == SAT_A_STAT && hwdata[1]) ovr_r <= 1'b0;
   end

   // Shared pins: aux audio makes both pins inputs
   assign gpio_out = gpio_r[1:0];
   assign gpio_oe_n = ctrl_r[SAT_C_AUX] ? 2'h3 : ~gpio_r[3:2];

   // ---- Bit clock domain ----
   // Local reset release on the bit clock
   always_ff @(posedge audio_bclk or negedge rst_n) begin
      if (!rst_n) brst_q <= 2'h0;
      else brst_q <= {brst_q[0], 1'b1};
   end
   assign brst_n = brst_q[1];

   // Quasi-static config levels cross on two flops
   always_ff @(posedge audio_bclk or negedge brst_n) begin
      if (!brst_n) begin
         bcfg_s1 <= 7'h00;
         bcfg_s2 <= 7'h00;
      end else begin
         bcfg_s1 <= {ctrl_r[SAT_C_TDM], wlen_r};
         bcfg_s2 <= bcfg_s1;
      end
   end
   assign b_tdm = bcfg_s2[6];
   assign b_wlen = bcfg_s2[5:0];

   // Line 4 is the aux pair: pin 0 data, pin 1 its own select
   assign wsv = {gpio_in[1], {4{audio_word_select}}};
   assign dv = {gpio_in[0], audio_data_line_d, audio_data_line_c,
                audio_data_line_b, audio_data_line_a};
   assign ws_rise = audio_word_select & ~ws_q[0];

   // TDM slot position; frame restarts one bit after select rises
   always_ff @(posedge audio_bclk or negedge brst_n) begin
      if (!brst_n) begin
         wpos_r <= 6'h00;
         sidx_r <= 3'h0;
      end else if (ws_rise) begin
         wpos_r <= 6'h00;
         sidx_r <= 3'h0;
      end else if (wpos_r == b_wlen) begin
         wpos_r <= 6'h00;
         sidx_r <= sidx_r + 3'h1;
      end else begin
         wpos_r <= wpos_r + 6'h01;
      end
   end

   // Per line shift capture; word closes on the bit where select flips, or on the last bit of each slot in TDM
   for (genvar i = 0; i < SAT_NLINE; i++) begin : g_line
      logic [31:0] sh_r;
      logic emit;
      assign emit = b_tdm ? (!ws_rise && wpos_r == b_wlen) : (wsv[i] != ws_q[i]);
      always_ff @(posedge audio_bclk or negedge brst_n) begin
         if (!brst_n) begin
            sh_r <= 32'h0;
            ws_q[i] <= 1'b0;
            hold[i] <= '0;
            tg_r[i] <= 1'b0;
         end else begin
            sh_r <= {sh_r[30:0], dv[i]};
            ws_q[i] <= wsv[i];
            if (emit) begin
               // Longer TDM slots keep their last 32 bits
               hold[i].data <= {sh_r[30:0], dv[i]};
               hold[i].slot <= b_tdm ? sidx_r : {2'h0, ws_q[i]};
               tg_r[i] <= ~tg_r[i];
            end
         end
      end
   end

   // Toggle per bit clock edge feeds the period meter
   always_ff @(posedge audio_bclk or negedge brst_n) begin
      if (!brst_n) tg_r[5] <= 1'b0;
      else tg_r[5] <= ~tg_r[5];
   end

   // ---- System clock domain ----
   // Event toggles and pin levels cross on two flops
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) begin
         tg_s1 <= 6'h00;
         tg_s2 <= 6'h00;
         tg_s3 <= 6'h00;
         gin_s1 <= 2'h0;
         gin_s2 <= 2'h0;
      end else begin
         tg_s1 <= tg_r;
         tg_s2 <= tg_s1;
         tg_s3 <= tg_s2;
         gin_s1 <= gpio_in;
         gin_s2 <= gin_s1;
      end
   end
   assign tg_new = tg_s2 ^ tg_s3;

   // Bit clock period in system clocks; a stopped clock saturates and fails
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) begin
         pcnt_r <= 8'h00;
         per_r <= 8'h00;
         bclk_ok_r <= 1'b0;
      end else if (tg_new[5]) begin
         pcnt_r <= 8'h01;
         per_r <= pcnt_r;
         bclk_ok_r <= pcnt_r >= 8'(SAT_PER_MIN_CYC) && pcnt_r >= plim_r
                      && pcnt_r <= 8'(SAT_PER_MAX_CYC);
      end else if (pcnt_r != 8'hFF) begin
         pcnt_r <= pcnt_r + 8'h01;
         if (pcnt_r >= 8'(SAT_PER_MAX_CYC)) bclk_ok_r <= 1'b0;
      end
   end
   assign bclk_ok = bclk_ok_r;

   // Transport selection: islands by default, surround gated by partner
   assign isl = ~ctrl_r[SAT_C_ISL_DIS];
   assign emb = ctrl_r[SAT_C_EMB];
   assign surr = isl & partner_new & (ctrl_r[SAT_C_SURR] | partner_surround);
   assign surround_active = surr;
   always_comb begin
      if (surr) mask[3:0] = 4'hF;
      else if (isl) mask[3:0] = ctrl_r[SAT_C_TWO_LINE] ? 4'h3 : 4'h1;
      else mask[3:0] = partner_new ? 4'h1 : 4'h3;
      mask[4] = ctrl_r[SAT_C_AUX];
   end
   // Islands only leave during blanking
   assign allow = isl ? blank : 1'b1;

   // New words; embedded audio replaces serial lines, aux stays independent
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         set_v[i] = tg_new[i] & mask[i] & bclk_ok_r & ~emb;
      end
      set_v[0] = set_v[0] | (emb & emb_valid);
      set_v[4] = tg_new[4] & mask[4] & bclk_ok_r;
   end

   // Lowest pending line first
   always_comb begin
      grant = 5'h00;
      for (int i = SAT_NLINE - 1; i >= 0; i--) begin
         if (pend_v[i]) grant = 5'(1 << i);
      end
      if (!load) grant = 5'h00;
   end
   assign load = (|pend_v) & allow & (~out_v_r | link_ready);

   // One pending word per line; a new word overwrites and flags overrun
   for (genvar i = 0; i < SAT_NLINE; i++) begin : g_pend
      always_ff @(posedge clk or negedge rs_n) begin
         if (!rs_n) begin
            pend_v[i] <= 1'b0;
            pend[i] <= '0;
         end else if (set_v[i]) begin
            pend_v[i] <= 1'b1;
            pend[i] <= (i == 0 && emb) ? emb_smp : hold[i];
         end else if (grant[i]) begin
            pend_v[i] <= 1'b0;
         end
      end
   end

   // Registered link output stage, held until the framer takes it
   always_ff @(posedge clk or negedge rs_n) begin
      if (!rs_n) begin
         out_v_r <= 1'b0;
         out_r <= '0;
      end else if (load) begin
         out_v_r <= 1'b1;
         out_r.island <= isl;
         for (int i = 0; i < SAT_NLINE; i++) begin
            if (grant[i]) begin
               out_r.smp <= pend[i];
               out_r.line <= 3'(i);
            end
         end
      end else if (link_ready) begin
         out_v_r <= 1'b0;
      end
   end
   assign link_valid = out_v_r;
   assign link_out = out_r;

   // ---- Checks ----
   a_out_hold_stable: assert property (@(posedge clk) disable iff (!rs_n)
      link_valid && !link_ready |=> link_valid && $stable(link_out))
      else $error("link word changed while stalled");
   a_island_in_blank: assert property (@(posedge clk) disable iff (!rs_n)
      load && isl |-> blank ##1 link_valid && link_out.island)
      else $error("island word loaded outside blanking");
   a_frame_line_set: assert property (@(posedge clk) disable iff (!rs_n)
      load && !isl && grant[1] |-> !partner_new)
      else $error("line B sent in frame mode to new partner");
   a_surround_gate: assert property (@(posedge clk) disable iff (!rs_n)
      load && (grant[2] || grant[3]) |-> surr && !emb)
      else $error("lines C or D sent without surround");
   a_surround_auto: assert property (@(posedge clk) disable iff (!rs_n)
      partner_surround && partner_new && isl |-> surround_active && mask[3:0] == 4'hF)
      else $error("upstream surround not followed");
   a_aux_pins_in: assert property (@(posedge clk) disable iff (!rs_n)
      ctrl_r[SAT_C_AUX] |-> gpio_oe_n == 2'h3)
      else $error("aux pins still driven");
   a_bclk_range_ok: assert property (@(posedge clk) disable iff (!rs_n)
      $rose(bclk_ok_r) |-> per_r >= 8'(SAT_PER_MIN_CYC) && per_r <= 8'(SAT_PER_MAX_CYC))
      else $error("bit clock accepted out of range");
   a_serial_needs_clk: assert property (@(posedge clk) disable iff (!rs_n)
      $rose(pend_v[1]) |-> $past(bclk_ok_r))
      else $error("word taken without valid bit clock");
   a_emb_route: assert property (@(posedge clk) disable iff (!rs_n)
      emb && emb_valid |=> pend_v[0] && pend[0] == $past(emb_smp))
      else $error("embedded word not queued");
   a_tdm_frame_start: assert property (@(posedge audio_bclk) disable iff (!brst_n)
      b_tdm && ws_rise |=> wpos_r == 6'h00 && sidx_r == 3'h0 ##1 wpos_r == 6'h01)
      else $error("TDM frame not restarted");
endmodule : sat_audio_in

// ===== testbench/sat_src_model.sv
// Audio source model: bit clock, word select, four data lines and aux pair
`timescale 1ns/100ps
module sat_src_model (
   output logic bclk,
   output logic ws,
   output logic [3:0] dat,
   output logic aux_d,
   output logic aux_ws
);
   // Pins at rest; the bit clock stands low between frames
   initial begin
      bclk = 1'b0;
      ws = 1'b0;
      dat = 4'h0;
      aux_d = 1'b0;
      aux_ws = 1'b0;
   end

   // One stereo frame; line n carries word plus n, aux carries the inverse
   // Callers keep hp inside the legal clock range unless testing a refusal
   task automatic frame(input logic [31:0] l, input logic [31:0] r, input realtime hp);
      logic [31:0] w;
      logic [31:0] v;
      int b;
      for (int k = 0; k <= 64; k++) begin
         ws = (k >= 32 && k < 64); // 64 bit clocks per select period
         aux_ws = ws;
         w = (k <= 32) ? l : r;
         b = (k == 0) ? 0 : ((k <= 32) ? 32 - k : 64 - k); // MSB one clock after select
         for (int n = 0; n < 4; n++) begin
            v = w + 32'(n);
            dat[n] = v[b];
         end
         aux_d = ~w[b];
         #(hp) bclk = 1'b1;
         #(hp) bclk = 1'b0;
      end
      // Released lines show the inverse so a stale bit cannot pass
      dat = ~dat;
      aux_d = ~aux_d;
   endtask : frame
endmodule : sat_src_model

// ===== testbench/sat_audio_in_tb.sv
// Self-checking bench for the serial audio input and transport block
`timescale 1ns/100ps
module sat_audio_in_tb
   import sat_pkg::*;
();
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, blank = 1'b0;
   logic link_ready = 1'b0, emb_valid = 1'b0, partner_new = 1'b1, partner_surround = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'h0, gpio_out, gpio_oe_n;
   logic [2:0] hsize = 3'h2;
   sat_smp_t emb_smp = '0;
   sat_link_t link_out;
   logic hreadyout, hresp, link_valid, surround_active, bclk_ok, bclk, ws, aux_d, aux_ws;
   logic [3:0] dat;
   int err_total = 0, check_count = 0, cyc = 0;

   always #2.5 clk = ~clk;

   sat_audio_in dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .audio_bclk(bclk),
      .audio_word_select(ws), .audio_data_line_a(dat[0]), .audio_data_line_b(dat[1]),
      .audio_data_line_c(dat[2]), .audio_data_line_d(dat[3]), .gpio_in({aux_ws, aux_d}),
      .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .emb_valid(emb_valid), .emb_smp(emb_smp),
      .blank(blank), .partner_new(partner_new), .partner_surround(partner_surround),
      .link_ready(link_ready), .link_valid(link_valid), .link_out(link_out),
      .surround_active(surround_active), .bclk_ok(bclk_ok));

   sat_src_model src (.bclk(bclk), .ws(ws), .dat(dat), .aux_d(aux_d), .aux_ws(aux_ws));

   task automatic chk(input logic ok, input string m);
      check_count++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk

   // Single word transfer; address held until hready, data until hready again
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   // Wait for a word, stall two cycles so it must stand, then accept it
   task automatic getw(input logic [31:0] d, input logic [2:0] s, input logic [2:0] ln,
                       input logic isl);
      int t;
      t = 0;
      do begin
         @(negedge clk);
         t++;
      end while (link_valid !== 1'b1 && t < 3000);
      repeat (2) @(negedge clk);
      chk(link_valid === 1'b1 && link_out === {d, s, ln, isl}, "link word");
      @(posedge clk);
      link_ready <= 1'b1;
      @(posedge clk);
      link_ready <= 1'b0;
   endtask : getw

   // Send a slow frame and collect left then right words, lowest line first
   task automatic frm(input logic [31:0] l, input logic [31:0] r, input logic [4:0] m,
                      input logic isl);
      fork
         src.frame(l, r, 75.0);
         for (int s = 0; s < 2; s++) begin
            for (int n = 0; n < 5; n++) begin
               if (m[n]) begin
                  getw(n == 4 ? ~(s ? r : l) : (s ? r : l) + 32'(n), 3'(s), 3'(n), isl);
               end
            end
         end
      join
   endtask : frm

   task automatic t_regs;
      logic [31:0] x;
      logic [7:0] ad [5] = '{SAT_A_CTRL, SAT_A_TDM, SAT_A_GPIO, SAT_A_PLIM, 8'h20};
      logic [31:0] ex [5] = '{32'h0, {26'h0, SAT_WLEN_RST}, 32'h0, 32'h0, 32'h0};
      wr(8'h20, 32'hFFFFFFFF);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ad[i], 32'h0, x);
         chk(x === ex[i], "reset value or unmapped read");
      end
      chk(hresp === 1'b0 && hreadyout === 1'b1, "okay response");
      wr(SAT_A_GPIO, 32'hE);
      repeat (2) @(negedge clk);
      chk(gpio_out === 2'b10 && gpio_oe_n === 2'b00, "gpio drive");
      wr(SAT_A_CTRL, 32'h8);
      repeat (2) @(negedge clk);
      chk(gpio_oe_n === 2'b11, "aux owns pins");
      $display("TEST regs done");
   endtask : t_regs

   task automatic t_range;
      wr(SAT_A_CTRL, 32'h0);
      blank <= 1'b1;
      src.frame(32'h12345678, 32'h9ABCDEF0, 15.0);
      chk(bclk_ok === 1'b0 && link_valid === 1'b0, "fast clock refused");
      frm(32'h80000001, 32'h7FFFFFFE, 5'b00001, 1'b1);
      chk(bclk_ok === 1'b1, "clock in range");
      // A pixel limit above the bit clock period refuses an otherwise legal clock
      wr(SAT_A_PLIM, 32'h28);
      src.frame(32'h01234567, 32'h89ABCDEF, 75.0);
      chk(bclk_ok === 1'b0 && link_valid === 1'b0, "pixel clock limit refused");
      wr(SAT_A_PLIM, 32'h0);
      $display("TEST range done");
   endtask : t_range

   task automatic t_island;
      logic [31:0] x;
      blank <= 1'b0;
      src.frame(32'hCAFE0001, 32'hCAFE0002, 75.0);
      repeat (10) @(negedge clk);
      chk(link_valid === 1'b0, "held outside blanking");
      @(posedge clk);
      blank <= 1'b1;
      getw(32'hCAFE0002, 3'h1, 3'h0, 1'b1);
      bus(1'b0, SAT_A_STAT, 32'h0, x);
      chk(x[1] === 1'b1, "overrun flagged");
      $display("TEST island done");
   endtask : t_island

   // Frame transport ignores blanking; partner type picks the lines
   task automatic t_frame;
      wr(SAT_A_CTRL, 32'h1);
      blank <= 1'b0;
      frm(32'h0F0F1111, 32'hF0F02222, 5'b00001, 1'b0);
      partner_new <= 1'b0;
      frm(32'h0F0F3333, 32'hF0F04444, 5'b00011, 1'b0);
      partner_new <= 1'b1;
      blank <= 1'b1;
      wr(SAT_A_CTRL, 32'h4);
      frm(32'h0A0A5555, 32'hA0A06666, 5'b00011, 1'b1);
      wr(SAT_A_CTRL, 32'h3);
      @(negedge clk);
      chk(surround_active === 1'b0, "no surround in frame mode");
      $display("TEST frame done");
   endtask : t_frame

   task automatic t_surr;
      wr(SAT_A_CTRL, 32'h2);
      @(negedge clk);
      chk(surround_active === 1'b1, "surround on");
      frm(32'h11110000, 32'h22220000, 5'b01111, 1'b1);
      partner_new <= 1'b0;
      repeat (2) @(negedge clk);
      chk(surround_active === 1'b0, "no surround with legacy partner");
      wr(SAT_A_CTRL, 32'h0);
      partner_new <= 1'b1;
      partner_surround <= 1'b1;
      repeat (2) @(negedge clk);
      chk(surround_active === 1'b1, "surround from upstream");
      frm(32'h33330000, 32'h44440000, 5'b01111, 1'b1);
      partner_surround <= 1'b0;
      $display("TEST surround done");
   endtask : t_surr

   task automatic t_aux;
      wr(SAT_A_CTRL, 32'h8);
      frm(32'h5555AAAA, 32'hAAAA5555, 5'b10001, 1'b1);
      $display("TEST aux done");
   endtask : t_aux

   // TDM with 32-bit slots: words pile up outside blanking, only the last survives
   task automatic t_tdm;
      logic [31:0] x;
      wr(SAT_A_CTRL, 32'h10);
      blank <= 1'b0;
      src.frame(32'h13572468, 32'h8642ACE1, 75.0);
      @(posedge clk);
      blank <= 1'b1;
      getw(32'h8642ACE1, 3'h0, 3'h0, 1'b1);
      wr(SAT_A_STAT, 32'h2);
      bus(1'b0, SAT_A_STAT, 32'h0, x);
      chk(x[1] === 1'b0, "overrun cleared");
      $display("TEST tdm done");
   endtask : t_tdm

   task automatic t_emb;
      wr(SAT_A_CTRL, 32'h20);
      @(posedge clk);
      emb_smp <= {32'h5A5AC3C3, 3'h2};
      emb_valid <= 1'b1;
      @(posedge clk);
      emb_valid <= 1'b0;
      getw(32'h5A5AC3C3, 3'h2, 3'h0, 1'b1);
      $display("TEST embedded done");
   endtask : t_emb

   task automatic summarize;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   // Main sequence after four cycles of reset
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_regs;
      t_range;
      t_island;
      t_frame;
      t_surr;
      t_aux;
      t_tdm;
      t_emb;
      summarize;
   end

   // Hang guard, well above the roughly 20k cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         summarize;
      end
   end
endmodule : sat_audio_in_tb
